// ==== rtl/tsr_consts.svh ====
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH
// ----------------------------------------
// register pointers
// ----------------------------------------
`define TSR_PTR_TEMP    8'h00
`define TSR_PTR_CONFIG  8'h01
`define TSR_PTR_UPPER   8'h02
`define TSR_PTR_LOWER   8'h03
`define TSR_PTR_UNLOCK  8'h04
`define TSR_PTR_USER_A  8'h05
`define TSR_PTR_USER_B  8'h06
`define TSR_PTR_OFFSET  8'h07
`define TSR_PTR_USER_C  8'h08
`define TSR_PTR_IDENT   8'h0F
// ----------------------------------------
// reset values
// ----------------------------------------
`define TSR_RST_TEMP    16'h8000
`define TSR_RST_CONFIG  16'h0220
`define TSR_RST_UPPER   16'h6000
`define TSR_RST_LOWER   16'h8000
`define TSR_RST_UNLOCK  16'h0000
`define TSR_RST_OFFSET  16'h0000
`define TSR_RST_USER    16'h0000
// arbitrary neutral identity value
`define TSR_IDENT_CODE  16'h5A5A
// ----------------------------------------
// field positions and bus framing
// ----------------------------------------
`define TSR_CFG_READY   13
`define TSR_CFG_HIALRT  15
`define TSR_CFG_LOALRT  14
`define TSR_CFG_BUSY    12
`define TSR_CFG_RO_MASK 16'hF003
`define TSR_TGT_ADDR    7'h48
`define TSR_BIT_LAST    3'h7
`define TSR_RW_BIT      0
`define TSR_PIN_IDLE    1'h1
// unlock word bit that lets a register write reach the cells
`define TSR_UNLOCK_EN   15
`endif

// ==== rtl/tsr_pkg.sv ====
package tsr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_WR_DATA,
    ST_DATA_ACK,
    ST_RD_DATA,
    ST_RD_ACK
  } tsr_state_t;

  // nonvolatile image of the reset defaults
  typedef struct packed {
    logic [15:0] config_word;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] user_a;
    logic [15:0] user_b;
    logic [15:0] offset;
    logic [15:0] user_c;
  } tsr_nv_t;

  // serial pins as seen by the core
  typedef struct packed {
    logic scl_s;
    logic sda_s;
  } tsr_pins_t;

  typedef struct packed {
    tsr_state_t  state;
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    tsr_pins_t   prev;
    logic [2:0]  bit_cnt;
    logic [7:0]  shift;
    logic        is_read;
    logic        byte_hi;
    logic [7:0]  pointer;
    logic [15:0] word_out;
    logic [7:0]  data_hi;
    logic        sda_oe;
    logic        sda_out;
    logic        loaded;
    logic [15:0] temp;
    logic [15:0] config_word;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] unlock;
    logic [15:0] user_a;
    logic [15:0] user_b;
    logic [15:0] offset;
    logic [15:0] user_c;
    logic        nv_write;
    logic [7:0]  nv_ptr;
    logic [15:0] nv_data;
  } tsr_state_all_t;
endpackage

// ==== rtl/tsr_regbank.sv ====
`timescale 1ns/100ps
`include "tsr_consts.svh"
// Notes on behaviour
// - temperature word at pointer 00h is read only; writes never change it
// - result is two's complement, one step equals 7.8125 millidegrees
// - after reset temperature reads 8000h until first full conversion lands
// - upper limit at 02h is read/write, default 6000h
// - lower limit at 03h is read/write, default 8000h
// - config, limits, offset, user words load from nonvolatile cells at reset
// - host-programmed nonvolatile codes become the defaults for later resets
// - pointers 00h-08h and 0Fh decode; 0Fh identity read only, 04h unlock
// - ready flag clears on temperature or config read, sets on new result
// - serial target only: clock input, data in/out, host starts everything
module tsr_regbank (
  // clock and reset
  input  wire logic           CLK_SYS,
  input  wire logic           ARST_N,
  // two-wire serial pins
  input  wire logic           SCL_IN,
  input  wire logic           SDA_IN,
  output logic                SDA_OUT,
  output logic                SDA_OE,
  // conversion engine
  input  wire logic           CONV_VALID,
  input  wire logic [15:0]    CONV_RESULT,
  input  wire logic           HIGH_EVENT,
  input  wire logic           LOW_EVENT,
  input  wire logic           NV_BUSY,
  // nonvolatile image
  input  wire tsr_pkg::tsr_nv_t NV_IMAGE,
  // register views for the core
  output logic [15:0]         CONFIG_WORD,
  output logic [15:0]         UPPER_LIMIT,
  output logic [15:0]         LOWER_LIMIT,
  output logic [15:0]         TEMP_OFFSET,
  output logic [15:0]         NV_UNLOCK,
  output logic                NV_WRITE,
  output logic [7:0]          NV_WRITE_PTR,
  output logic [15:0]         NV_WRITE_DATA
);

  tsr_pkg::tsr_state_all_t r;
  tsr_pkg::tsr_state_all_t next_r;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_cond;
  logic                    stop_cond;
  logic                    wr_strobe;
  logic [15:0]             wr_word;
  logic                    rd_load;
  logic [15:0]             rd_word;
  logic                    byte_end;

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  function automatic logic [15:0] read_mux(input tsr_pkg::tsr_state_all_t s, input logic [7:0] p);
    case (p)
      `TSR_PTR_TEMP:   read_mux = s.temp;
      `TSR_PTR_CONFIG: read_mux = s.config_word;
      `TSR_PTR_UPPER:  read_mux = s.upper;
      `TSR_PTR_LOWER:  read_mux = s.lower;
      `TSR_PTR_UNLOCK: read_mux = s.unlock;
      `TSR_PTR_USER_A: read_mux = s.user_a;
      `TSR_PTR_USER_B: read_mux = s.user_b;
      `TSR_PTR_OFFSET: read_mux = s.offset;
      `TSR_PTR_USER_C: read_mux = s.user_c;
      `TSR_PTR_IDENT:  read_mux = `TSR_IDENT_CODE;
      default:         read_mux = 16'h0000;
    endcase
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b);
    shift_in = {s[6:0], b};
  endfunction

  function automatic logic [15:0] merge_config(input logic [15:0] w, input logic [15:0] cur);
    merge_config = (w & ~`TSR_CFG_RO_MASK) | (cur & `TSR_CFG_RO_MASK);
  endfunction

  function automatic logic nv_backed(input logic [7:0] p);
    case (p)
      `TSR_PTR_CONFIG, `TSR_PTR_UPPER, `TSR_PTR_LOWER, `TSR_PTR_USER_A,
      `TSR_PTR_USER_B, `TSR_PTR_OFFSET, `TSR_PTR_USER_C: nv_backed = 1'b1;
      default:                                           nv_backed = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // bus condition detection
  // ----------------------------------------
  // target-only pin sampling
  assign scl_rise   = r.scl_sync[1] & ~r.prev.scl_s;
  assign scl_fall   = ~r.scl_sync[1] & r.prev.scl_s;
  assign start_cond = r.scl_sync[1] & r.prev.scl_s & r.prev.sda_s & ~r.sda_sync[1];
  assign stop_cond  = r.scl_sync[1] & r.prev.scl_s & ~r.prev.sda_s & r.sda_sync[1];
  assign byte_end   = scl_rise & (r.bit_cnt == `TSR_BIT_LAST);
  assign rd_word    = read_mux(r, r.pointer);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r             = r;
    wr_strobe          = 1'b0;
    rd_load            = 1'b0;
    wr_word            = 16'h0000;
    next_r.nv_write    = 1'b0;
    next_r.scl_sync    = {r.scl_sync[0], SCL_IN};
    next_r.sda_sync    = {r.sda_sync[0], SDA_IN};
    next_r.prev.scl_s  = r.scl_sync[1];
    next_r.prev.sda_s  = r.sda_sync[1];

    if (!r.loaded && !NV_BUSY) begin
      next_r.loaded      = 1'b1;
      next_r.config_word = (NV_IMAGE.config_word & ~`TSR_CFG_RO_MASK);
      next_r.upper       = NV_IMAGE.upper;
      next_r.lower       = NV_IMAGE.lower;
      next_r.user_a      = NV_IMAGE.user_a;
      next_r.user_b      = NV_IMAGE.user_b;
      next_r.offset      = NV_IMAGE.offset;
      next_r.user_c      = NV_IMAGE.user_c;
    end
    next_r.config_word[`TSR_CFG_BUSY] = NV_BUSY | ~r.loaded;

    // ----------------------------------------
    // serial target sequencing
    // ----------------------------------------
    if (scl_rise) begin
      next_r.shift   = shift_in(r.shift, r.sda_sync[1]);
      next_r.bit_cnt = r.bit_cnt + 3'h1;
    end
    if (stop_cond) begin
      next_r.state  = tsr_pkg::ST_IDLE;
      next_r.sda_oe = 1'b0;
    end else if (start_cond) begin
      // start or repeated start reopens the address phase
      next_r.state   = tsr_pkg::ST_ADDR;
      next_r.bit_cnt = 3'h0;
      next_r.sda_oe  = 1'b0;
    end else begin
      case (r.state)
        tsr_pkg::ST_IDLE: begin
          next_r.sda_oe = 1'b0;
        end
        tsr_pkg::ST_ADDR: begin
          if (byte_end) begin
            if (next_r.shift[7:1] == `TSR_TGT_ADDR) begin
              next_r.is_read = next_r.shift[`TSR_RW_BIT];
              next_r.state   = tsr_pkg::ST_ADDR_ACK;
            end else begin
              // another target: keep off the bus until the next start
              next_r.state = tsr_pkg::ST_IDLE;
            end
          end
        end
        tsr_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (!r.sda_oe) begin
              // pull data low for the acknowledge slot
              next_r.sda_oe  = 1'b1;
              next_r.sda_out = 1'b0;
            end else if (r.is_read) begin
              // first data bit leaves on this same falling edge
              rd_load         = 1'b1;
              next_r.sda_out  = rd_word[15];
              next_r.word_out = rd_word << 1;
              next_r.bit_cnt  = 3'h0;
              next_r.state    = tsr_pkg::ST_RD_DATA;
            end else begin
              next_r.sda_oe  = 1'b0;
              next_r.bit_cnt = 3'h0;
              next_r.state   = tsr_pkg::ST_PTR;
            end
          end
        end
        tsr_pkg::ST_PTR: begin
          if (byte_end) begin
            next_r.pointer = next_r.shift;
            next_r.byte_hi = 1'b1;
            next_r.state   = tsr_pkg::ST_DATA_ACK;
          end
        end
        tsr_pkg::ST_WR_DATA: begin
          if (byte_end) begin
            next_r.state = tsr_pkg::ST_DATA_ACK;
            if (r.byte_hi) begin
              next_r.data_hi = next_r.shift;
              next_r.byte_hi = 1'b0;
            end else begin
              // whole word in hand: commit, pointer stays put
              wr_strobe      = 1'b1;
              wr_word        = {r.data_hi, next_r.shift};
              next_r.byte_hi = 1'b1;
            end
          end
        end
        tsr_pkg::ST_DATA_ACK: begin
          if (scl_fall) begin
            next_r.sda_oe  = ~r.sda_oe;
            next_r.sda_out = 1'b0;
            if (r.sda_oe) begin
              next_r.bit_cnt = 3'h0;
              next_r.state   = tsr_pkg::ST_WR_DATA;
            end
          end
        end
        tsr_pkg::ST_RD_DATA: begin
          if (scl_fall) begin
            if (r.bit_cnt == 3'h0) begin
              // eight bits out: hand the line to the host
              next_r.sda_oe = 1'b0;
              next_r.state  = tsr_pkg::ST_RD_ACK;
            end else begin
              next_r.sda_out  = r.word_out[15];
              next_r.word_out = r.word_out << 1;
            end
          end
        end
        tsr_pkg::ST_RD_ACK: begin
          if (scl_fall) begin
            if (!r.shift[0]) begin
              next_r.sda_oe   = 1'b1;
              next_r.sda_out  = r.word_out[15];
              next_r.word_out = r.word_out << 1;
              next_r.bit_cnt  = 3'h0;
              next_r.state    = tsr_pkg::ST_RD_DATA;
            end else begin
              // not acknowledged: the read is over
              next_r.state = tsr_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          next_r.state = tsr_pkg::ST_IDLE;
        end
      endcase
    end

    // ----------------------------------------
    // register writes and flags
    // ----------------------------------------
    // host writes land
    if (wr_strobe) begin
      case (r.pointer)
        `TSR_PTR_CONFIG: next_r.config_word = merge_config(wr_word, next_r.config_word);
        `TSR_PTR_UPPER:  next_r.upper       = wr_word;
        `TSR_PTR_LOWER:  next_r.lower       = wr_word;
        `TSR_PTR_UNLOCK: next_r.unlock      = wr_word;
        `TSR_PTR_USER_A: next_r.user_a      = wr_word;
        `TSR_PTR_USER_B: next_r.user_b      = wr_word;
        `TSR_PTR_OFFSET: next_r.offset      = wr_word;
        `TSR_PTR_USER_C: next_r.user_c      = wr_word;
        default: ;
      endcase
    end
    if (wr_strobe && r.unlock[`TSR_UNLOCK_EN] && nv_backed(r.pointer)) begin
      next_r.nv_write = 1'b1;
      next_r.nv_ptr   = r.pointer;
      next_r.nv_data  = wr_word;
    end
    if (rd_load && (r.pointer == `TSR_PTR_TEMP || r.pointer == `TSR_PTR_CONFIG)) begin
      next_r.config_word[`TSR_CFG_READY] = 1'b0;
    end
    if (rd_load && r.pointer == `TSR_PTR_CONFIG) begin
      next_r.config_word[`TSR_CFG_HIALRT] = 1'b0;
      next_r.config_word[`TSR_CFG_LOALRT] = 1'b0;
    end
    if (HIGH_EVENT) begin
      next_r.config_word[`TSR_CFG_HIALRT] = 1'b1;
    end
    if (LOW_EVENT) begin
      next_r.config_word[`TSR_CFG_LOALRT] = 1'b1;
    end
    if (CONV_VALID) begin
      next_r.temp                        = CONV_RESULT;
      next_r.config_word[`TSR_CFG_READY] = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // reset code for the whole state, temperature included
  localparam tsr_pkg::tsr_state_all_t RST_STATE = '{
    state:       tsr_pkg::ST_IDLE,
    scl_sync:    {2{`TSR_PIN_IDLE}},
    sda_sync:    {2{`TSR_PIN_IDLE}},
    prev:        {2{`TSR_PIN_IDLE}},
    temp:        `TSR_RST_TEMP,
    config_word: `TSR_RST_CONFIG,
    upper:       `TSR_RST_UPPER,
    lower:       `TSR_RST_LOWER,
    unlock:      `TSR_RST_UNLOCK,
    user_a:      `TSR_RST_USER,
    user_b:      `TSR_RST_USER,
    offset:      `TSR_RST_OFFSET,
    user_c:      `TSR_RST_USER,
    default:     '0
  };

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      r <= RST_STATE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign SDA_OUT       = r.sda_out;
  assign SDA_OE        = r.sda_oe;
  assign CONFIG_WORD   = r.config_word;
  assign UPPER_LIMIT   = r.upper;
  assign LOWER_LIMIT   = r.lower;
  assign TEMP_OFFSET   = r.offset;
  assign NV_UNLOCK     = r.unlock;
  assign NV_WRITE      = r.nv_write;
  assign NV_WRITE_PTR  = r.nv_ptr;
  assign NV_WRITE_DATA = r.nv_data;
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`include "tsr_consts.svh"
module tb;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             cv = 1'b0;
  logic [15:0]      cr = 16'h0000;
  logic [15:0]      w;
  logic             scl, sda_in, sda_out, sda_oe;
  int               fail_count = 0;
  int               comparisons = 0;
  tsr_pkg::tsr_nv_t nv = {16'h0220, 16'h6000, 16'h8000, 16'h1111, 16'h2222, 16'h0000, 16'h3333};
  logic [7:0]       pa [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0F};
  logic [15:0]      dv [10] = '{16'h8000, 16'h0220, 16'h6000, 16'h8000, 16'h0000, 16'h1111, 16'h2222,
                                16'h0000, 16'h3333, `TSR_IDENT_CODE};
  always #2.5 clk = ~clk;
  tsr_regbank u_tsr_regbank (.CLK_SYS(clk), .ARST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_in), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .CONV_VALID(cv), .CONV_RESULT(cr), .HIGH_EVENT(1'b0), .LOW_EVENT(1'b0), .NV_BUSY(1'b0),
    .NV_IMAGE(nv), .CONFIG_WORD(), .UPPER_LIMIT(), .LOWER_LIMIT(), .TEMP_OFFSET(), .NV_UNLOCK(), .NV_WRITE(),
    .NV_WRITE_PTR(), .NV_WRITE_DATA());
  tsr_host u_tsr_host (.clk(clk), .sda_out(sda_out), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));
  task check(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task rd(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] v;
    u_tsr_host.read_reg(p, v);
    check(v, e);
  endtask
  task do_reset;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task conv;
    cr = 16'hFF80;
    cv = 1'b1;
    @(posedge clk);
    #1 cv = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    end_sim;
  end
  initial begin
    do_reset;
    for (int i = 0; i < 10; i++) rd(pa[i], dv[i]);
    $display("defaults test done");
    for (int i = 1; i < 9; i++) begin
      w = (i == 1) ? 16'h0064 : {8'h5A, pa[i]};
      u_tsr_host.write_reg(pa[i], w);
      rd(pa[i], w);
    end
    u_tsr_host.write_reg(8'h00, 16'hFFFF);
    u_tsr_host.write_reg(8'h0F, 16'hFFFF);
    u_tsr_host.write_reg(8'h0A, 16'hFFFF);
    rd(8'h00, 16'h8000);
    rd(8'h0F, `TSR_IDENT_CODE);
    rd(8'h0A, 16'h0000);
    rd(8'h02, 16'h5A02);
    $display("write test done");
    conv;
    rd(8'h01, 16'h2064);
    rd(8'h01, 16'h0064);
    conv;
    rd(8'h00, 16'hFF80);
    rd(8'h01, 16'h0064);
    $display("conversion test done");
    nv.upper = 16'h1234;
    do_reset;
    rd(8'h02, 16'h1234);
    rd(8'h00, 16'h8000);
    rd(8'h04, 16'h0000);
    check(u_tsr_host.nacks, 16'h0000);
    $display("second reset test done");
    end_sim;
  end
endmodule

// ==== tb/tsr_host.sv ====
`timescale 1ns/100ps
`include "tsr_consts.svh"
module tsr_host (
  // clock
  input  wire logic clk,
  // device pins
  input  wire logic sda_out,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda_in
);
  logic        drv = 1'b1;
  logic [15:0] nacks = 16'h0000;
  // open-drain line, pulled up
  assign sda_in = drv & ~(sda_oe & ~sda_out);
  initial scl = 1'b1;
  task q;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task bit_io(input logic b, output logic s);
    drv = b;
    q;
    scl = 1'b1;
    q;
    s = sda_in;
    scl = 1'b0;
    q;
  endtask
  task start;
    drv = 1'b1;
    q;
    scl = 1'b1;
    q;
    drv = 1'b0;
    q;
    scl = 1'b0;
    q;
  endtask
  task stop;
    drv = 1'b0;
    q;
    scl = 1'b1;
    q;
    drv = 1'b1;
    q;
  endtask
  task byte_io(input logic [7:0] tx, input logic ak, output logic [7:0] rx, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ak, a);
  endtask
  task send(input logic [7:0] b);
    logic [7:0] r;
    logic       a;
    byte_io(b, 1'b1, r, a);
    if (a !== 1'b0) nacks = nacks + 16'h0001;
  endtask
  task write_reg(input logic [7:0] p, input logic [15:0] d);
    start;
    send({`TSR_TGT_ADDR, 1'b0});
    send(p);
    send(d[15:8]);
    send(d[7:0]);
    stop;
  endtask
  task read_reg(input logic [7:0] p, output logic [15:0] d);
    logic a;
    start;
    send({`TSR_TGT_ADDR, 1'b0});
    send(p);
    start;
    send({`TSR_TGT_ADDR, 1'b1});
    byte_io(8'hFF, 1'b0, d[15:8], a);
    byte_io(8'hFF, 1'b1, d[7:0], a);
    stop;
  endtask
endmodule

// ==== tb/tsr_regbank_properties.sv ====
`timescale 1ns/100ps
module tsr_checker (
  // clock and reset
  input wire logic             CLK_SYS,
  input wire logic             ARST_N,
  // serial and engine inputs
  input wire logic             SCL_IN,
  input wire logic             SDA_OE,
  input wire logic             CONV_VALID,
  input wire tsr_pkg::tsr_nv_t NV_IMAGE,
  // register views
  input wire logic [15:0]      CONFIG_WORD,
  input wire logic [15:0]      UPPER_LIMIT,
  input wire logic [15:0]      LOWER_LIMIT,
  input wire logic [15:0]      TEMP_OFFSET,
  input wire logic [15:0]      NV_UNLOCK
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  a_upper_load: assert property ($rose(ARST_N) |-> ##[0:3] UPPER_LIMIT == NV_IMAGE.upper)
    else $error("upper load");
  a_lower_load: assert property ($rose(ARST_N) |-> ##[0:3] LOWER_LIMIT == NV_IMAGE.lower)
    else $error("lower load");
  a_offset_load: assert property ($rose(ARST_N) |-> ##[0:3] TEMP_OFFSET == NV_IMAGE.offset)
    else $error("offset load");
  a_config_load: assert property ($rose(ARST_N) |-> ##[0:3] CONFIG_WORD[11:2] == NV_IMAGE.config_word[11:2])
    else $error("config load");
  a_unlock_zero: assert property ($rose(ARST_N) |-> NV_UNLOCK == 16'h0000)
    else $error("unlock reset");
  a_ready_set: assert property (CONV_VALID |-> ##[1:3] CONFIG_WORD[13])
    else $error("ready flag");
  a_limits_kept: assert property (CONV_VALID |=> $stable(UPPER_LIMIT) && $stable(LOWER_LIMIT))
    else $error("limits moved");
  a_sda_timing: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("sda while scl high");
endmodule
bind tsr_regbank tsr_checker u_tsr_checker (.CLK_SYS, .ARST_N, .SCL_IN, .SDA_OE, .CONV_VALID, .NV_IMAGE,
  .CONFIG_WORD, .UPPER_LIMIT, .LOWER_LIMIT, .TEMP_OFFSET, .NV_UNLOCK);
